// [core/btf_top.sv]
// Operation
// - Each trigger line is offered inside the device as a source just like a digital input.
// - A selected trigger line can drive the image capture begin trigger.
// - Every broadcast message arriving from the transport is accepted and evaluated.
// - One device-wide authorization key is write-only and reads back as zero.
// - No line fires unless the message device key equals the stored key.
// - A read/write index selects which line the group key and mask accesses address.
// - Each line has its own read/write group match mask used for checking.
// - Each line has its own read/write group match key used for checking.
// - The message mask ANDed with the line mask must be non-zero.
// - The message group key must equal the line group key.
// - A message meeting all three conditions raises that line.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "btf_map.svh"
module btf_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        msg_valid,
  input  wire logic [31:0] msg_device_key,
  input  wire logic [31:0] msg_group_key,
  input  wire logic [31:0] msg_group_mask,
  output logic      [3:0]  trigger_line,
  output logic             image_capture_begin_trigger
);
  localparam int unsigned N = btf_pkg::NUM_LINES;

  btf_pkg::btf_word_t device_authorization_key_q;
  btf_pkg::btf_idx_t  trigger_line_index_select_q;
  btf_pkg::btf_word_t group_match_key_q  [N];
  btf_pkg::btf_word_t group_match_mask_q [N];
  logic [8:0]         begin_src_q;
  logic [3:0]         trigger_line_q;
  logic               begin_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic [3:0]         seen_q;
  btf_pkg::btf_state_t state_q;
  logic               msg_valid_q;
  btf_pkg::btf_word_t mdev_q;
  btf_pkg::btf_word_t mgkey_q;
  btf_pkg::btf_word_t mgmask_q;
  logic [N-1:0]       hit;
  logic               wr_acc;
  logic               rd_acc;

  // Address decode shared by read and write paths
  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == `BTF_OFF_DEV_KEY) || (a == `BTF_OFF_SEL) || (a == `BTF_OFF_GRP_MASK)
              || (a == `BTF_OFF_GRP_KEY) || (a == `BTF_OFF_BEGIN_SRC) || (a == `BTF_OFF_STATUS);
  endfunction

  // Access phase; slave answers in the second access cycle (one wait state)
  assign wr_acc = psel && penable && pwrite && !pready_q;
  assign rd_acc = psel && penable && !pwrite && !pready_q;

  // One-cycle ready pulse, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !known_addr(paddr);
    end
  end

  // Device key and selector writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_authorization_key_q  <= `BTF_RST_KEY;
      trigger_line_index_select_q <= `BTF_RST_SEL;
      begin_src_q                 <= `BTF_RST_BEGIN;
    end else if (wr_acc) begin
      if (paddr == `BTF_OFF_DEV_KEY)
        device_authorization_key_q <= pwdata;
      if (paddr == `BTF_OFF_SEL)
        trigger_line_index_select_q <= pwdata[`BTF_SEL_LSB +: btf_pkg::IDX_W];
      if (paddr == `BTF_OFF_BEGIN_SRC)
        begin_src_q <= pwdata[8:0];
    end
  end

  // Per-line group settings, addressed through the selector
  generate
    for (genvar g = 0; g < N; g++) begin : g_line
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          group_match_key_q[g]  <= `BTF_RST_KEY;
          group_match_mask_q[g] <= `BTF_RST_MASK;
        end else if (wr_acc && (trigger_line_index_select_q == btf_pkg::btf_idx_t'(g))) begin
          if (paddr == `BTF_OFF_GRP_MASK)
            group_match_mask_q[g] <= pwdata;
          if (paddr == `BTF_OFF_GRP_KEY)
            group_match_key_q[g] <= pwdata;
        end
      end

      btf_line_match u_match (
        .msg_group_key    (mgkey_q),
        .msg_group_mask   (mgmask_q),
        .group_match_key  (group_match_key_q[g]),
        .group_match_mask (group_match_mask_q[g]),
        .hit              (hit[g])
      );
    end
  endgenerate

  // Read mux; the device key reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (paddr)
        `BTF_OFF_SEL:       prdata_q <= {30'h0, trigger_line_index_select_q};
        `BTF_OFF_GRP_MASK:  prdata_q <= group_match_mask_q[trigger_line_index_select_q];
        `BTF_OFF_GRP_KEY:   prdata_q <= group_match_key_q[trigger_line_index_select_q];
        `BTF_OFF_BEGIN_SRC: prdata_q <= {23'h0, begin_src_q};
        `BTF_OFF_STATUS:    prdata_q <= {28'h0, seen_q};
        default:            prdata_q <= 32'h0000_0000;
      endcase
    end else begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // Capture every message; registering cuts the compare path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_valid_q <= 1'b0;
      mdev_q      <= 32'h0000_0000;
      mgkey_q     <= 32'h0000_0000;
      mgmask_q    <= 32'h0000_0000;
    end else begin
      msg_valid_q <= msg_valid;
      if (msg_valid) begin
        mdev_q   <= msg_device_key;
        mgkey_q  <= msg_group_key;
        mgmask_q <= msg_group_mask;
      end
    end
  end

  // Evaluation state, for visibility
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= btf_pkg::BTF_IDLE;
    end else begin
      case (state_q)
        btf_pkg::BTF_IDLE: if (msg_valid) state_q <= btf_pkg::BTF_EVAL;
        btf_pkg::BTF_EVAL: if (!msg_valid) state_q <= btf_pkg::BTF_IDLE;
        default:           state_q <= btf_pkg::BTF_IDLE;
      endcase
    end
  end

  // Trigger pulses: device key gates every line's own match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_line_q <= 4'h0;
    end else if (msg_valid_q && (mdev_q == device_authorization_key_q)) begin
      trigger_line_q <= hit;
    end else begin
      trigger_line_q <= 4'h0;
    end
  end

  // Capture begin follows the chosen line when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      begin_q <= 1'b0;
    end else begin
      begin_q <= begin_src_q[`BTF_BEGIN_EN_BIT] && msg_valid_q && (mdev_q == device_authorization_key_q)
                 && hit[begin_src_q[1:0]];
    end
  end

  // Sticky record of lines fired; a fire wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 4'h0;
    end else begin
      seen_q <= ((wr_acc && paddr == `BTF_OFF_STATUS) ? (seen_q & ~pwdata[3:0]) : seen_q) | trigger_line_q;
    end
  end

  assign trigger_line                = trigger_line_q;
  assign image_capture_begin_trigger = begin_q;
  assign prdata                      = prdata_q;
  assign pready                      = pready_q;
  assign pslverr                     = pslverr_q;

  // Assertions
  sequence s_auth_msg;
    msg_valid && (msg_device_key == device_authorization_key_q);
  endsequence

  property p_key_gate;
    @(posedge pclk) disable iff (!presetn)
      (trigger_line_q != 4'h0) |-> $past(msg_valid_q) && ($past(mdev_q) == $past(device_authorization_key_q));
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("trigger without key match");

  property p_pulse_one;
    @(posedge pclk) disable iff (!presetn)
      (trigger_line_q != 4'h0) && !$past(msg_valid) |=> (trigger_line_q == 4'h0);
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("trigger held too long");

  property p_latency;
    @(posedge pclk) disable iff (!presetn)
      s_auth_msg ##1 (hit != 4'h0) |=> (trigger_line_q != 4'h0);
  endproperty
  a_latency: assert property (p_latency) else $error("matching message lost");

  property p_mask_zero;
    @(posedge pclk) disable iff (!presetn)
      (msg_valid_q && (mgmask_q & group_match_mask_q[0]) == 32'h0) |=> !trigger_line_q[0];
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("line 0 fired with no mask overlap");

  property p_gkey;
    @(posedge pclk) disable iff (!presetn)
      (msg_valid_q && mgkey_q != group_match_key_q[0]) |=> !trigger_line_q[0];
  endproperty
  a_gkey: assert property (p_gkey) else $error("line 0 fired with wrong group key");

  property p_discard;
    @(posedge pclk) disable iff (!presetn)
      (msg_valid_q && hit == 4'h0) |=> (trigger_line_q == 4'h0) && $stable(device_authorization_key_q);
  endproperty
  a_discard: assert property (p_discard) else $error("unmatched message had an effect");

  property p_devkey_hidden;
    @(posedge pclk) disable iff (!presetn)
      (rd_acc && paddr == `BTF_OFF_DEV_KEY) |=> (prdata_q == 32'h0);
  endproperty
  a_devkey_hidden: assert property (p_devkey_hidden) else $error("device key readable");

  property p_sel_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `BTF_OFF_SEL) |=> (trigger_line_index_select_q == $past(pwdata[1:0]));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selector not written");

  property p_begin;
    @(posedge pclk) disable iff (!presetn)
      image_capture_begin_trigger |-> $past(begin_src_q[`BTF_BEGIN_EN_BIT]) && $past(hit[begin_src_q[1:0]])
        && $past(msg_valid_q) && (trigger_line_q != 4'h0);
  endproperty
  a_begin: assert property (p_begin) else $error("capture begin without enabled source");

  // State bit must mirror the captured valid, else it misreports
  property p_state_track;
    @(posedge pclk) disable iff (!presetn)
      (state_q == btf_pkg::BTF_EVAL) == msg_valid_q;
  endproperty
  a_state_track: assert property (p_state_track) else $error("evaluation state out of step");

  property p_devkey_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `BTF_OFF_DEV_KEY) |=> (device_authorization_key_q == $past(pwdata));
  endproperty
  a_devkey_write: assert property (p_devkey_write) else $error("device key not stored");

  property p_gmask_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `BTF_OFF_GRP_MASK && trigger_line_index_select_q == 2'h0)
        |=> (group_match_mask_q[0] == $past(pwdata));
  endproperty
  a_gmask_write: assert property (p_gmask_write) else $error("line 0 group mask not stored");

  property p_gkey_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `BTF_OFF_GRP_KEY && trigger_line_index_select_q == 2'h0)
        |=> (group_match_key_q[0] == $past(pwdata));
  endproperty
  a_gkey_write: assert property (p_gkey_write) else $error("line 0 group key not stored");

  // Line 1 must fire on its own match whatever the other lines do
  sequence s_line_hit1;
    msg_valid_q && (mdev_q == device_authorization_key_q) && hit[1];
  endsequence

  property p_line_indep;
    @(posedge pclk) disable iff (!presetn)
      s_line_hit1 |=> trigger_line_q[1];
  endproperty
  a_line_indep: assert property (p_line_indep) else $error("line 1 match lost");

  property p_begin_fire;
    @(posedge pclk) disable iff (!presetn)
      (begin_src_q[`BTF_BEGIN_EN_BIT] && msg_valid_q && (mdev_q == device_authorization_key_q)
        && hit[begin_src_q[1:0]]) |=> image_capture_begin_trigger;
  endproperty
  a_begin_fire: assert property (p_begin_fire) else $error("capture begin missed");

  // A fire is recorded even when software clears in the same cycle
  property p_seen_set;
    @(posedge pclk) disable iff (!presetn)
      trigger_line_q[0] |=> seen_q[0];
  endproperty
  a_seen_set: assert property (p_seen_set) else $error("line 0 fire not recorded");
endmodule
`default_nettype wire

// [core/btf_map.svh]
`ifndef BTF_MAP_SVH
`define BTF_MAP_SVH

// Register byte offsets
`define BTF_OFF_DEV_KEY     12'h000
`define BTF_OFF_SEL         12'h004
`define BTF_OFF_GRP_MASK    12'h008
`define BTF_OFF_GRP_KEY     12'h00c
`define BTF_OFF_BEGIN_SRC   12'h010
`define BTF_OFF_STATUS      12'h014

// Field positions
`define BTF_SEL_LSB         0
`define BTF_BEGIN_EN_BIT    8
`define BTF_STATUS_PEND_BIT 0

// Reset values
`define BTF_RST_KEY         32'h0000_0000
`define BTF_RST_MASK        32'h0000_0000
`define BTF_RST_SEL         2'h0
`define BTF_RST_BEGIN       9'h000

`endif

// [core/btf_pkg.sv]
package btf_pkg;
  localparam int unsigned NUM_LINES = 4;
  localparam int unsigned IDX_W     = 2;
  typedef logic [31:0] btf_word_t;
  typedef logic [IDX_W-1:0] btf_idx_t;
  // Message evaluation pipeline state
  typedef enum logic [1:0] {
    BTF_IDLE = 2'b01,
    BTF_EVAL = 2'b10
  } btf_state_t;
endpackage

// [core/btf_line_match.sv]
`timescale 1ns/1ps
`default_nettype none
// Per-line comparison of one message against stored group settings
module btf_line_match (
  input  wire logic [31:0] msg_group_key,
  input  wire logic [31:0] msg_group_mask,
  input  wire logic [31:0] group_match_key,
  input  wire logic [31:0] group_match_mask,
  output logic             hit
);
  // Mask overlap and key equality both required
  assign hit = (|(msg_group_mask & group_match_mask)) && (msg_group_key == group_match_key);
endmodule
`default_nettype wire

// [dv/btf_host.sv]
`timescale 1ns/1ps
`default_nettype none
module btf_host (
  input  wire logic        pclk,
  output logic             msg_valid,
  output logic      [31:0] msg_device_key,
  output logic      [31:0] msg_group_key,
  output logic      [31:0] msg_group_mask
);
  logic [95:0] q_msg[$];

  initial begin
    msg_valid = 1'b0;
    {msg_device_key, msg_group_key, msg_group_mask} = '0;
  end

  // Queue one message: device key, group key, group mask
  task automatic push(input logic [31:0] dk, input logic [31:0] gk, input logic [31:0] gm);
    q_msg.push_back({dk, gk, gm});
  endtask

  // One message per clock; idle fields flip so stale values never look valid
  always @(posedge pclk) begin
    if (q_msg.size() != 0) begin
      msg_valid <= 1'b1;
      {msg_device_key, msg_group_key, msg_group_mask} <= q_msg.pop_front();
    end else begin
      msg_valid <= 1'b0;
      {msg_device_key, msg_group_key, msg_group_mask} <= ~{msg_device_key, msg_group_key, msg_group_mask};
    end
  end
endmodule
`default_nettype wire

// [dv/btf_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "btf_map.svh"
module btf_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, msg_valid, begin_trig;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, msg_dk, msg_gk, msg_gm, dev_key;
  logic [31:0] grp_key[4], grp_mask[4];
  logic [3:0]  trig, sticky;
  logic [8:0]  begin_src;
  logic [33:0] an;
  logic [4:0]  tn;
  logic [33:0] q_apb[$];
  logic [4:0]  q_trig[$];
  int          mismatches, n_tests, cycles, seed;

  btf_top i_btf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg_valid(msg_valid), .msg_device_key(msg_dk), .msg_group_key(msg_gk), .msg_group_mask(msg_gm),
    .trigger_line(trig), .image_capture_begin_trigger(begin_trig));
  btf_host i_btf_host (.pclk(pclk), .msg_valid(msg_valid), .msg_device_key(msg_dk),
    .msg_group_key(msg_gk), .msg_group_mask(msg_gm));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // APB cycle; note is {is_read, slverr, data}, taken off by the monitor
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] note);
    q_apb.push_back(note);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {1'b0, err, 32'h0});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h0, {1'b1, err, e});
  endtask

  // Reference filter: all lines judged on their own
  task automatic msg(input logic [31:0] dk, input logic [31:0] gk, input logic [31:0] gm);
    logic [3:0] hit;
    for (int l = 0; l < 4; l++) hit[l] = dk == dev_key && (gm & grp_mask[l]) != 0 && gk == grp_key[l];
    if (hit != 4'h0) q_trig.push_back({begin_src[8] & hit[begin_src[1:0]], hit});
    sticky |= hit;
    i_btf_host.push(dk, gk, gm);
  endtask

  // Per-line settings read back through the selector
  task automatic readback();
    for (int l = 0; l < 4; l++) begin
      wr(`BTF_OFF_SEL, l, 1'b0);
      rd(`BTF_OFF_SEL, l, 1'b0);
      rd(`BTF_OFF_GRP_MASK, grp_mask[l], 1'b0);
      rd(`BTF_OFF_GRP_KEY, grp_key[l], 1'b0);
    end
  endtask

  // Compare each answer or trigger pulse with the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      an = q_apb.size() != 0 ? q_apb.pop_front() : '1;
      check("pslverr", {31'h0, pslverr}, {31'h0, an[32]});
      if (an[33]) check("prdata", prdata, an[31:0]);
    end
    if (trig !== 4'h0 || begin_trig !== 1'b0) begin
      tn = q_trig.size() != 0 ? q_trig.pop_front() : 5'h0;
      check("trigger", {27'h0, begin_trig, trig}, {27'h0, tn});
    end
  end

  // Hang guard: a few hundred cycles are needed
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    seed = 87;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {dev_key, begin_src, sticky} = '0;
    foreach (grp_key[l]) begin
      grp_key[l]  = 32'h0;
      grp_mask[l] = 32'h0;
    end
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    readback();
    rd(`BTF_OFF_STATUS, 32'h0, 1'b0);
    dev_key = $random(seed);
    wr(`BTF_OFF_DEV_KEY, dev_key, 1'b0);
    rd(`BTF_OFF_DEV_KEY, 32'h0, 1'b0);
    // Lines 0 and 1 share a group key; each mask owns one low bit
    for (int l = 0; l < 4; l++) begin
      grp_key[l] = l < 2 ? 32'h0000_00a5 : $random(seed);
      grp_mask[l] = ($random(seed) & 32'hffff_fff0) | (32'h1 << l);
      wr(`BTF_OFF_SEL, l, 1'b0);
      wr(`BTF_OFF_GRP_MASK, grp_mask[l], 1'b0);
      wr(`BTF_OFF_GRP_KEY, grp_key[l], 1'b0);
    end
    begin_src = 9'h102;
    wr(`BTF_OFF_BEGIN_SRC, {23'h0, begin_src}, 1'b0);
    rd(`BTF_OFF_BEGIN_SRC, {23'h0, begin_src}, 1'b0);
    rd(12'h018, 32'h0, 1'b1);
    wr(12'h018, 32'hffff_ffff, 1'b1);
    readback();
    // Directed back-to-back messages
    msg(dev_key, 32'ha5, 32'h1);
    msg(dev_key, 32'ha5, 32'h3);
    msg(~dev_key, 32'ha5, 32'h3);
    msg(dev_key, 32'ha5, 32'h4);
    msg(dev_key, grp_key[2], 32'hffff_ffff);
    msg(dev_key, grp_key[3] + 1, 32'hffff_ffff);
    // Random traffic, sometimes with gaps
    repeat (60) begin
      msg($random(seed) & 1 ? dev_key : $random(seed), grp_key[$random(seed) & 3],
          32'h1 << ($random(seed) & 31));
      if ($random(seed) & 1) @(posedge pclk);
    end
    while (q_trig.size() != 0 || i_btf_host.q_msg.size() != 0) @(posedge pclk);
    repeat (4) @(posedge pclk);
    rd(`BTF_OFF_STATUS, {28'h0, sticky}, 1'b0);
    wr(`BTF_OFF_STATUS, 32'hf, 1'b0);
    rd(`BTF_OFF_STATUS, 32'h0, 1'b0);
    readback();
    results();
  end
endmodule
`default_nettype wire
